// File: hw/conv_pkg.sv
// Constants, field layout and types for the converter control block.
// Function
// - Reference enable bit switches reference on.
// - Reference ready flag always reads one.
// - Gain field: 11=4x, 10=2x, 01=1x, 00=off.
// - Converter gain field programmable independently.
// - Reference usable as positive reference and channel.
// - Ten-bit SAR result in high/low pair.
// - Completion raises flag usable for wake.
// - Pin converts regardless of analog select.
// - Channel field selects sample-and-hold input.
// - Positive reference select chooses reference source.
// - Clock select: 000 div2, 100 div4.
// - One conversion clock period per bit.
// - Control logic runs on conversion clock.
// - Completion clears go, sets flag, stores result.
package conv_pkg;
  localparam int RES_W = 10;
  localparam int CHAN_W = 6;
  localparam int POSITIVE_REF_SELECT_W = 2;
  localparam int CS_W = 3;
  localparam int DIV_W = 7;

  localparam logic [11:0] ADDR_CONV_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CONV_CFG = 12'h004;
  localparam logic [11:0] ADDR_RES_HIGH = 12'h008;
  localparam logic [11:0] ADDR_RES_LOW = 12'h00C;
  localparam logic [11:0] ADDR_REF_CTRL = 12'h90C;

  localparam int REF_EN_BIT = 7;
  localparam int REF_RDY_BIT = 6;
  localparam int GAIN_LSB = 0;
  localparam int GO_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int CHAN_LSB = 0;
  localparam int POSITIVE_REF_SELECT_LSB = 8;
  localparam int CS_LSB = 12;

  localparam logic [CS_W-1:0] CS_DIV2 = 3'h0;
  localparam logic [CS_W-1:0] CS_DIV4 = 3'h4;
  localparam logic [CS_W-1:0] CS_DIV8 = 3'h1;
  localparam logic [CS_W-1:0] CS_DIV16 = 3'h5;
  localparam logic [CS_W-1:0] CS_DIV32 = 3'h2;
  localparam logic [CS_W-1:0] CS_DIV64 = 3'h6;
  localparam logic [1:0] CS_RC_LOW = 2'h3;

  localparam logic [DIV_W-1:0] DIV2 = 7'h02;
  localparam logic [DIV_W-1:0] DIV4 = 7'h04;
  localparam logic [DIV_W-1:0] DIV8 = 7'h08;
  localparam logic [DIV_W-1:0] DIV16 = 7'h10;
  localparam logic [DIV_W-1:0] DIV32 = 7'h20;
  localparam logic [DIV_W-1:0] DIV64 = 7'h40;

  typedef enum logic [1:0] {
    GAIN_OFF = 2'b00,
    GAIN_1X  = 2'b01,
    GAIN_2X  = 2'b10,
    GAIN_4X  = 2'b11
  } gain_t;

  typedef enum logic [0:0] {
    SAR_IDLE = 1'b0,
    SAR_CONV = 1'b1
  } sar_state_t;
endpackage

// File: hw/sar_if.sv
// Handshake between the control logic and the successive approximation core.
`timescale 1ns/1ns
interface sar_if;
  logic                          tick;
  logic                          start;
  logic                          cmp;
  logic                          busy;
  logic                          done;
  logic [conv_pkg::RES_W-1:0]    result;
  logic [conv_pkg::RES_W-1:0]    trial;
  modport ctrl (output tick, output start, output cmp,
                input busy, input done, input result, input trial);
  modport core (input tick, input start, input cmp,
                output busy, output done, output result, output trial);
endinterface

// File: hw/sar_core.sv
// Successive approximation engine, one result bit per conversion tick.
`timescale 1ns/1ns
module sar_core #(
  parameter int IDX_W = $clog2(conv_pkg::RES_W)
) (
  input  wire logic pclk,
  input  wire logic presetn,
  sar_if.core       s
);
  localparam logic [IDX_W-1:0] TOP = IDX_W'(conv_pkg::RES_W - 1);

  conv_pkg::sar_state_t          state;
  logic [IDX_W-1:0]              bit_idx;
  wire  [conv_pkg::RES_W-1:0]    cur_mask;
  wire  [conv_pkg::RES_W-1:0]    kept;
  wire                           last;

  assign cur_mask = conv_pkg::RES_W'(1) << bit_idx;
  // A low comparator answer means the trial overshot; drop that bit.
  assign kept = s.cmp ? s.trial : (s.trial & ~cur_mask);
  assign last = (bit_idx == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= conv_pkg::SAR_IDLE;
      bit_idx <= '0;
      s.trial <= '0;
      s.result <= '0;
      s.busy  <= 1'b0;
      s.done  <= 1'b0;
    end else begin
      s.done <= 1'b0;
      case (state)
        conv_pkg::SAR_IDLE: begin
          if (s.start && s.tick) begin
            state   <= conv_pkg::SAR_CONV;
            s.busy  <= 1'b1;
            bit_idx <= TOP;
            s.trial <= conv_pkg::RES_W'(1) << TOP;
          end
        end
        conv_pkg::SAR_CONV: begin
          if (s.tick && last) begin
            s.result <= kept;
            s.done   <= 1'b1;
            s.busy   <= 1'b0;
            state    <= conv_pkg::SAR_IDLE;
          end else if (s.tick) begin
            s.trial <= kept | (cur_mask >> 1);
            bit_idx <= bit_idx - 1'b1;
          end
        end
        default: state <= conv_pkg::SAR_IDLE;
      endcase
    end
  end
endmodule // sar_core

// File: hw/adc_reference_and_clock_control.sv
// Reference control, conversion clock selection and APB register file.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module adc_reference_and_clock_control (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic [11:0]                     paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            rc_clk_in,
  input  wire logic                            cmp_in,
  output logic                                 ref_enable,
  output logic [1:0]                           ref_gain,
  output logic [conv_pkg::CHAN_W-1:0]          channel,
  output logic [conv_pkg::POSITIVE_REF_SELECT_W-1:0]          pos_ref,
  output logic [conv_pkg::RES_W-1:0]           dac_code,
  output logic                                 sample_hold,
  output logic                                 conv_done_irq
);
  ////////////////////////////////////////////////////////////////////////////
  sar_if s ();

  sar_core u_core (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (s.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flip-flops before use.
  logic                            cmp_meta;
  logic                            cmp_sync;
  logic                            rc_meta;
  logic                            rc_sync;
  logic                            rc_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      rc_meta  <= 1'b0;
      rc_sync  <= 1'b0;
      rc_prev  <= 1'b0;
    end else begin
      cmp_meta <= cmp_in;
      cmp_sync <= cmp_meta;
      rc_meta  <= rc_clk_in;
      rc_sync  <= rc_meta;
      rc_prev  <= rc_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic                            go;
  logic                            done_flag;
  logic [conv_pkg::CS_W-1:0]       clk_sel;
  logic [conv_pkg::DIV_W-1:0]      div_cnt;
  logic                            tick;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock: a divided bus clock, or the RC clock pin.
  wire                             rc_sel;
  wire                             rc_rise;
  wire  [conv_pkg::DIV_W-1:0]      div_val;
  wire                             div_wrap;
  wire                             next_tick;
  wire  [conv_pkg::DIV_W-1:0]      next_div_cnt;

  assign rc_sel = (clk_sel[1:0] == conv_pkg::CS_RC_LOW);
  assign rc_rise = rc_sync && !rc_prev;
  assign div_val =
    (clk_sel == conv_pkg::CS_DIV2)  ? conv_pkg::DIV2 :
    (clk_sel == conv_pkg::CS_DIV4)  ? conv_pkg::DIV4 :
    (clk_sel == conv_pkg::CS_DIV8)  ? conv_pkg::DIV8 :
    (clk_sel == conv_pkg::CS_DIV16) ? conv_pkg::DIV16 :
    (clk_sel == conv_pkg::CS_DIV32) ? conv_pkg::DIV32 :
                                      conv_pkg::DIV64;
  assign div_wrap = (div_cnt >= div_val - 1'b1);
  // The divided tick tracks the bus clock, so it scales with its rate.
  assign next_tick = rc_sel ? rc_rise : div_wrap;
  assign next_div_cnt = (rc_sel || div_wrap) ? '0 : div_cnt + 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core hookup. Start is only taken on a tick, so with the RC clock a go
  // write may wait a long while before anything visible happens.
  assign s.tick  = tick;
  assign s.start = go && !s.busy;
  // The comparator answer reaches the core three cycles after a trial, so
  // only the divide-by-two clock settles bits on stale answers.
  assign s.cmp   = cmp_sync;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. Answering from the setup phase lets the read data come from a flip-flop with no wait state.
  wire                             setup;
  wire                             wr;
  wire                             sel_ref;
  wire                             sel_ctrl;
  wire                             sel_cfg;
  wire                             sel_hi;
  wire                             sel_lo;
  wire                             mapped;
  wire                             wr_ref;
  wire                             wr_ctrl;
  wire                             wr_cfg;
  wire  [31:0]                     rd_ref;
  wire  [31:0]                     rd_ctrl;
  wire  [31:0]                     rd_cfg;
  wire  [31:0]                     rd_hi;
  wire  [31:0]                     rd_lo;
  wire  [31:0]                     rd_mux;

  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;
  assign sel_ref  = (paddr == conv_pkg::ADDR_REF_CTRL);
  assign sel_ctrl = (paddr == conv_pkg::ADDR_CONV_CTRL);
  assign sel_cfg  = (paddr == conv_pkg::ADDR_CONV_CFG);
  assign sel_hi   = (paddr == conv_pkg::ADDR_RES_HIGH);
  assign sel_lo   = (paddr == conv_pkg::ADDR_RES_LOW);
  assign mapped = sel_ref || sel_ctrl || sel_cfg || sel_hi || sel_lo;
  assign wr_ref  = wr && sel_ref;
  assign wr_ctrl = wr && sel_ctrl;
  assign wr_cfg  = wr && sel_cfg;

  // Ready reads one at all times; there is no settling to wait for.
  assign rd_ref = {24'h000000, ref_enable, 1'b1, 4'h0, ref_gain};
  assign rd_ctrl = {29'h00000000, s.busy, done_flag, go};
  assign rd_cfg = {17'h00000, clk_sel, 2'h0, pos_ref, 2'h0, channel};
  assign rd_hi = {22'h000000, s.result[conv_pkg::RES_W-1:8], 8'h00};
  assign rd_lo = {24'h000000, s.result[7:0]};
  assign rd_mux = sel_ref  ? rd_ref  :
                  sel_ctrl ? rd_ctrl :
                  sel_cfg  ? rd_cfg  :
                  sel_hi   ? rd_hi   :
                  sel_lo   ? rd_lo   : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference control. Gain is its own field, apart from the enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_enable <= 1'b0;
      ref_gain   <= conv_pkg::GAIN_OFF;
    end else if (wr_ref) begin
      ref_enable <= pwdata[conv_pkg::REF_EN_BIT];
      ref_gain   <= pwdata[conv_pkg::GAIN_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion configuration. The channel goes to the sample-and-hold
  // mux whatever the pin's analog select, which this block never sees.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel <= '0;
      pos_ref <= '0;
      clk_sel <= conv_pkg::CS_DIV2;
    end else if (wr_cfg) begin
      channel <= pwdata[conv_pkg::CHAN_LSB +: conv_pkg::CHAN_W];
      pos_ref <= pwdata[conv_pkg::POSITIVE_REF_SELECT_LSB +: conv_pkg::POSITIVE_REF_SELECT_W];
      clk_sel <= pwdata[conv_pkg::CS_LSB +: conv_pkg::CS_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Go and completion. A set arriving with a clear always wins.
  wire                             go_set;
  wire                             flag_clr;
  wire                             next_go;
  wire                             next_done_flag;

  assign go_set = wr_ctrl && pwdata[conv_pkg::GO_BIT];
  assign flag_clr = wr_ctrl && pwdata[conv_pkg::DONE_BIT];
  assign next_go = go_set || (go && !s.done);
  assign next_done_flag = s.done || (done_flag && !flag_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go            <= 1'b0;
      done_flag     <= 1'b0;
      conv_done_irq <= 1'b0;
      dac_code      <= '0;
      sample_hold   <= 1'b0;
    end else begin
      go            <= next_go;
      done_flag     <= next_done_flag;
      conv_done_irq <= next_done_flag;
      dac_code      <= s.trial;
      sample_hold   <= s.busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_answer: assert property (
    setup |=> pready ##1 !pready || setup)
    else $error("pready not raised one cycle after setup");

  a_ref_ready_one: assert property (
    setup && !pwrite && sel_ref |=> prdata[conv_pkg::REF_RDY_BIT])
    else $error("reference ready flag read as zero");

  a_ref_enable_write: assert property (
    wr_ref |=> ref_enable == $past(pwdata[conv_pkg::REF_EN_BIT]))
    else $error("reference enable did not follow write");

  a_gain_write: assert property (
    wr_ref |=> ref_gain == $past(pwdata[1:0]) && ref_enable ==
      $past(pwdata[conv_pkg::REF_EN_BIT]))
    else $error("gain field did not follow write");

  a_gain_hold: assert property (
    !wr_ref |=> $stable(ref_gain) && $stable(ref_enable))
    else $error("reference fields changed without write");

  a_cfg_write: assert property (
    wr_cfg |=> channel == $past(pwdata[conv_pkg::CHAN_W-1:0])
      && pos_ref == $past(pwdata[conv_pkg::POSITIVE_REF_SELECT_LSB +: 2]))
    else $error("channel or reference select not stored");

  a_done_effects: assert property (
    s.done && !go_set |=> !go && done_flag && conv_done_irq)
    else $error("completion did not clear go and set flag");

  a_flag_set_wins: assert property (
    s.done && flag_clr |=> done_flag)
    else $error("completion lost against software clear");

  a_tick_div2: assert property (
    tick && clk_sel == conv_pkg::CS_DIV2 ##1 clk_sel == conv_pkg::CS_DIV2
      |-> !tick ##1 tick)
    else $error("divide by two tick spacing wrong");

  a_tick_div4: assert property (
    tick && clk_sel == conv_pkg::CS_DIV4
      ##1 (clk_sel == conv_pkg::CS_DIV4)[*3] |=> tick)
    else $error("divide by four tick spacing wrong");

  a_start_on_tick: assert property (
    $rose(s.busy) |-> $past(tick) && $past(go))
    else $error("conversion started off a conversion tick");

  a_bit_per_tick: assert property (
    s.busy && !tick |=> $stable(s.trial))
    else $error("approximation moved without a tick");

  a_rc_tick: assert property (
    rc_sel && $past(rc_sel) && tick |-> $past(rc_sync) && !$past(rc_prev))
    else $error("RC tick without RC clock edge");

  a_unmapped_err: assert property (
    setup && !mapped |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the bus answer and the conversion bookkeeping.
  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("error response outside an access cycle");

  a_idle_read_zero: assert property (
    !pready |-> prdata == 32'h00000000)
    else $error("read data not zero outside an access cycle");

  a_done_ends_busy: assert property (
    s.done |-> !s.busy && $past(s.busy))
    else $error("completion not at the end of a conversion");

  a_flag_clear: assert property (
    flag_clr && !s.done |=> !done_flag)
    else $error("completion flag not cleared by software");

  a_irq_follows_flag: assert property (
    conv_done_irq == done_flag)
    else $error("wake request differs from completion flag");

  a_go_hold: assert property (
    go && !s.done |=> go)
    else $error("go dropped before completion");

  a_hold_follow: assert property (
    sample_hold == $past(s.busy))
    else $error("sample and hold does not follow the core");

  a_dac_follow: assert property (
    dac_code == $past(s.trial))
    else $error("trial code output does not follow the core");

  a_cfg_hold: assert property (
    !wr_cfg |=> $stable(channel) && $stable(pos_ref) && $stable(clk_sel))
    else $error("configuration changed without write");

  a_rc_no_div: assert property (
    rc_sel |=> div_cnt == '0)
    else $error("divider ran while the RC clock is selected");

  a_div_bound: assert property (
    div_cnt < conv_pkg::DIV64)
    else $error("divider count out of range");

  a_first_trial: assert property (
    $rose(s.busy) |-> s.trial == (conv_pkg::RES_W'(1) << (conv_pkg::RES_W - 1)))
    else $error("conversion did not start at the top bit");

  a_result_on_done: assert property (
    $changed(s.result) |-> s.done)
    else $error("result changed outside a completion");

  c_conv_done: cover property (s.done);
  c_ref_on: cover property (wr_ref && pwdata[conv_pkg::REF_EN_BIT]);
  c_rc_conv: cover property (rc_sel && s.done);
  c_div64_conv: cover property (clk_sel == conv_pkg::CS_DIV64 && s.done);
  c_flag_clash: cover property (s.done && flag_clr);
endmodule // adc_reference_and_clock_control

// File: test/analog_model.sv
// Behavioural analog side: channel levels, comparator and RC oscillator.
`timescale 1ns/1ns
module analog_model (
  input  wire logic       pclk,
  input  wire logic [5:0] channel,
  input  wire logic [1:0] pos_ref,
  input  wire logic [9:0] dac_code,
  input  wire logic       sample_hold,
  output logic            cmp_in,
  output logic            rc_clk_in
);
  logic       chatter;
  logic [9:0] level;

  ////////////////////////////////////////////////////////////////////////////
  // Every pin converts, analog select or not, so no channel is gated off.
  assign level = {channel, 4'hB};

  // Outside a conversion the comparator output carries no meaning, so it
  // toggles each cycle rather than resting on a value a design could lean on.
  always @(posedge pclk) begin
    chatter <= ~chatter;
  end

  assign cmp_in = sample_hold ? (level >= dac_code) : chatter;

  ////////////////////////////////////////////////////////////////////////////
  // The RC oscillator runs free at 400 ns, out of phase with the bus clock.
  initial begin
    chatter = 1'b0;
    rc_clk_in = 1'b0;
    #13;
    forever #200 rc_clk_in = ~rc_clk_in;
  end
endmodule  // analog_model

// File: test/testbench.sv
// Self-checking bench for the converter reference and clock control block.
`timescale 1ns/1ns
module testbench;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rc_clk_in;
  logic        cmp_in;
  logic        ref_enable;
  logic [1:0]  ref_gain;
  logic [5:0]  channel;
  logic [1:0]  pos_ref;
  logic [9:0]  dac_code;
  logic        sample_hold;
  logic        conv_done_irq;
  int          failures;
  int          compares;

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  adc_reference_and_clock_control i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_clk_in(rc_clk_in),
    .cmp_in(cmp_in), .ref_enable(ref_enable), .ref_gain(ref_gain),
    .channel(channel), .pos_ref(pos_ref), .dac_code(dac_code),
    .sample_hold(sample_hold), .conv_done_irq(conv_done_irq));

  analog_model i_analog (
    .pclk(pclk), .channel(channel), .pos_ref(pos_ref), .dac_code(dac_code),
    .sample_hold(sample_hold), .cmp_in(cmp_in), .rc_clk_in(rc_clk_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The master holds the whole request until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    // Outputs launched by the accepting edge are looked at once settled.
    @(negedge pclk);
    chk("write error", 32'h0, {31'h0, err});
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a,
                        input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(name, exp, rd);
    chk("read error", 32'h0, {31'h0, err});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    rd_chk("ref ctrl reset", conv_pkg::ADDR_REF_CTRL, 32'h40);
    rd_chk("cfg reset", conv_pkg::ADDR_CONV_CFG, 32'h0);
    rd_chk("ctrl reset", conv_pkg::ADDR_CONV_CTRL, 32'h0);
    chk("ref pins reset", 32'h0, {29'h0, ref_enable, ref_gain});
    $display("test reset values done");
  endtask

  // Reserved bits and the ready flag are written as ones to show the reserved bits still read zero.
  task automatic test_ref;
    logic [31:0] d;
    for (int g = 0; g < 4; g++) begin
      for (int e = 0; e < 2; e++) begin
        d = (e << 7) | g;
        wr(conv_pkg::ADDR_REF_CTRL, d | 32'h7C);
        rd_chk("ref ctrl", conv_pkg::ADDR_REF_CTRL, d | 32'h40);
        chk("ref enable pin", e, {31'h0, ref_enable});
        chk("ref gain pin", g, {30'h0, ref_gain});
      end
    end
    $display("test reference control done");
  endtask

  task automatic test_unmapped;
    logic [31:0] rd;
    logic        err;
    wr(conv_pkg::ADDR_CONV_CFG, 32'h0000_0215);
    apb(1'b1, 12'h014, 32'hFFFF_FFFF, rd, err);
    chk("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h010, 32'h0, rd, err);
    chk("unmapped read error", 32'h1, {31'h0, err});
    chk("unmapped read data", 32'h0, rd);
    rd_chk("cfg kept", conv_pkg::ADDR_CONV_CFG, 32'h0000_0215);
    chk("channel pin", 32'h15, {26'h0, channel});
    chk("pos ref pin", 32'h2, {30'h0, pos_ref});
    $display("test unmapped access done");
  endtask

  // Results are judged only where a tick leaves room for the comparator
  // synchroniser; at the two fastest clocks only the timing is judged.
  task automatic test_conv(input logic [2:0] cs, input int period,
                           input int idx);
    logic [5:0] chan;
    logic [9:0] lvl;
    int         n;
    int         k;
    chan = {idx[2:0], 3'h5};
    lvl = {chan, 4'hB};
    wr(conv_pkg::ADDR_CONV_CFG, {17'h0, cs, 2'h0, idx[1:0], 2'h0, chan});
    chk("channel pin", chan, {26'h0, channel});
    chk("pos ref pin", idx[1:0], {30'h0, pos_ref});
    wr(conv_pkg::ADDR_CONV_CTRL, 32'h1);
    k = 0;
    while (sample_hold !== 1'b1 && k < 2000) begin
      @(negedge pclk);
      k++;
    end
    n = 0;
    while (sample_hold === 1'b1 && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    if (k >= 2000 || n >= 2000) begin
      failures++;
      conclude();
    end
    if (period == 0) begin
      chk("rc hold length", 32'h1, {31'h0, n >= 79 && n <= 81});
    end else begin
      chk("hold length", period * 10, n);
    end
    k = 0;
    while (conv_done_irq !== 1'b1 && k < 20) begin
      @(negedge pclk);
      k++;
    end
    chk("done irq", 32'h1, {31'h0, conv_done_irq});
    rd_chk("ctrl after done", conv_pkg::ADDR_CONV_CTRL, 32'h2);
    if (period == 0 || period >= 8) begin
      rd_chk("result high", conv_pkg::ADDR_RES_HIGH, lvl & 10'h300);
      rd_chk("result low", conv_pkg::ADDR_RES_LOW, lvl & 10'h0FF);
    end
    wr(conv_pkg::ADDR_CONV_CTRL, 32'h2);
    rd_chk("ctrl cleared", conv_pkg::ADDR_CONV_CTRL, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, conv_done_irq});
    $display("test conversion with clock code %b done", cs);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_ref();
    test_unmapped();
    test_conv(3'h0, 2, 0);
    test_conv(3'h4, 4, 1);
    test_conv(3'h1, 8, 2);
    test_conv(3'h5, 16, 3);
    test_conv(3'h2, 32, 4);
    test_conv(3'h6, 64, 5);
    test_conv(3'h3, 0, 6);
    test_conv(3'h7, 0, 7);
    conclude();
  end
endmodule  // testbench
